// ===== enc_cmd_pkg.sv
package enc_cmd_pkg;
  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_POS_RD = 8'h42;
  localparam logic [7:0] CMD_POS_SET = 8'h43;
  localparam logic [7:0] CMD_ANALOG_RD = 8'h44;
  localparam logic [7:0] CMD_CNT_RD = 8'h46;
  localparam logic [7:0] CMD_CNT_INC = 8'h47;
  localparam logic [7:0] CMD_CNT_CLR = 8'h49;
  localparam logic [7:0] CMD_DATA_RD = 8'h4a;
  localparam logic [7:0] CMD_DATA_WR = 8'h4b;
  localparam logic [7:0] CMD_FIELD_STAT = 8'h4c;
  localparam logic [7:0] CMD_FIELD_NEW = 8'h4d;
  localparam logic [7:0] CMD_FREE_RD = 8'h4e;
  localparam logic [7:0] CMD_ACCESS_SET = 8'h4f;
  localparam logic [7:0] CMD_STATUS_RD = 8'h50;
  localparam logic [7:0] CMD_TYPE_RD = 8'h52;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_ADDR_SET = 8'h55;
  localparam logic [7:0] CMD_SERIAL_RD = 8'h56;
  localparam logic [7:0] CMD_IF_CFG = 8'h57;
  localparam logic [7:0] ANALOG_TEMP_CH = 8'h48;
  // ==========================================================
  // Status codes
  localparam logic [7:0] SC_OK = 8'h00;
  localparam logic [7:0] SC_ALIGN = 8'h01;
  localparam logic [7:0] SC_TABLE = 8'h03;
  localparam logic [7:0] SC_CSUM_INT = 8'h06;
  localparam logic [7:0] SC_WDOG = 8'h07;
  localparam logic [7:0] SC_CNT_OVF = 8'h08;
  localparam logic [7:0] SC_PARITY = 8'h09;
  localparam logic [7:0] SC_RX_SUM = 8'h0a;
  localparam logic [7:0] SC_UNK_CMD = 8'h0b;
  localparam logic [7:0] SC_LEN = 8'h0c;
  localparam logic [7:0] SC_ARG = 8'h0d;
  localparam logic [7:0] SC_WR_PROT = 8'h0e;
  localparam logic [7:0] SC_ACCESS = 8'h0f;
  localparam logic [7:0] SC_FIXED = 8'h10;
  localparam logic [7:0] SC_WORD = 8'h11;
  localparam logic [7:0] SC_NO_FIELD = 8'h12;
  localparam logic [7:0] SC_CURRENT = 8'h1d;
  localparam logic [7:0] SC_TEMP = 8'h1e;
  localparam logic [7:0] SC_SPEED = 8'h1f;
  localparam logic [7:0] SC_ST_POS = 8'h20;
  // ==========================================================
  // Fault pin positions in the synchronised vector
  localparam int FB_ALIGN = 0;
  localparam int FB_TABLE = 1;
  localparam int FB_CSUM = 2;
  localparam int FB_WDOG = 3;
  localparam int FB_SPEED = 4;
  localparam int FB_ST_POS = 5;
  localparam int FB_CURRENT = 6;
  localparam int FB_TEMP = 7;
  localparam int FAULT_PINS = 8;
  // ==========================================================
  // Sizes and reset values
  localparam int BUF_BYTES = 8;
  localparam int REP_BYTES = 5;
  localparam int NUM_FIELDS = 8;
  localparam int FIELD_WORDS = 16;
  localparam logic [7:0] NUM_FIELDS_B = 8'h08;
  localparam logic [7:0] FIELD_WORDS_B = 8'h10;
  localparam logic [7:0] FIELD0_SIZE = 8'h04;
  localparam logic [7:0] FREE_RESET = 8'h7c;
  localparam logic [7:0] ADDR_RESET = 8'h40;
  localparam logic [7:0] MODE_RESET = 8'he4;
  localparam logic [7:0] CODE0_RESET = 8'h55;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [14:0] OFS_RESET = 15'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} state_t;
endpackage

// ===== pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import enc_cmd_pkg::*;

  // ==========================================================
  // Two-stage synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          meta <= 1'b0;
          dout[g] <= 1'b0;
        end else if (clk_en) begin
          meta <= din[g];
          dout[g] <= meta;
        end
      end
    end
  endgenerate
endmodule // pin_sync

// ===== field_store.sv
`timescale 1ns/1ns
module field_store (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic store_en,
  input wire logic create_en,
  input wire logic [7:0] field,
  input wire logic [7:0] word,
  input wire logic [7:0] new_size,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic [7:0] field_size,
  output logic [7:0] free_words,
  output logic [7:0] exist_fault,
  output logic [7:0] rd_fault,
  output logic [7:0] wr_fault,
  output logic [7:0] cr_fault
);
  import enc_cmd_pkg::*;

  logic [15:0] mem [NUM_FIELDS*FIELD_WORDS];
  logic [7:0] size_tab [NUM_FIELDS];
  logic [7:0] next_free;
  logic [2:0] idx;
  logic [6:0] addr;
  logic in_range;

  // ==========================================================
  // Fault checks
  always_comb begin
    idx = field[2:0];
    addr = {idx, word[3:0]};
    in_range = field < NUM_FIELDS_B;
    field_size = in_range ? size_tab[idx] : 8'h00;
    rdata = mem[addr];
    exist_fault = (field_size == 8'h00) ? SC_NO_FIELD : SC_OK; // see RULE8
    rd_fault = exist_fault;
    if (exist_fault == SC_OK && word >= field_size) begin
      rd_fault = SC_WORD; // see RULE8
    end
    wr_fault = rd_fault;
    if (rd_fault == SC_OK && idx == 3'd0) begin
      wr_fault = SC_WR_PROT; // see RULE8
    end
    // Fixed slots keep sizing trivial; free count still honours the total
    if (!in_range) begin
      cr_fault = SC_NO_FIELD;
    end else if (field_size != 8'h00) begin
      cr_fault = SC_FIXED; // see RULE9
    end else if (new_size == 8'h00 || new_size > FIELD_WORDS_B || new_size > free_words) begin
      cr_fault = SC_ARG; // see RULE7
    end else begin
      cr_fault = SC_OK;
    end
    next_free = create_en ? free_words - new_size : free_words;
  end

  // ==========================================================
  // Storage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_FIELDS; i++) begin
        size_tab[i] <= (i == 0) ? FIELD0_SIZE : 8'h00;
      end
      free_words <= FREE_RESET;
    end else if (clk_en) begin
      if (store_en) begin
        mem[addr] <= wdata;
      end
      if (create_en) begin
        size_tab[idx] <= new_size;
      end
      free_words <= next_free;
    end
  end
endmodule // field_store

// ===== enc_cmd_status.sv
`timescale 1ns/1ns
// ==========================================================
// Notes on behaviour
// RULE1 - Decode one command byte per request
// RULE2 - Data field read, store, status, create, free
// RULE3 - Protected commands carry access byte, default 55h
// RULE4 - No fault gives status 00h
// RULE5 - Init faults report 01h, 03h, 06h
// RULE6 - Parity 09h, checksum 0Ah, unknown 0Bh
// RULE7 - Wrong length 0Ch, bad argument 0Dh
// RULE8 - Write protect 0Eh, word 11h, missing 12h
// RULE9 - Wrong access 0Fh, fixed size 10h
// RULE10 - Overspeed 1Fh, unreliable single-turn 20h
// RULE11 - Current 1Dh, temperature 1Eh, overflow 08h
// RULE12 - Watchdog restart reports 07h
// RULE13 - Hold latest fault until read or cleared
// RULE14 - Controller reads status after refused request
module enc_cmd_status #(
  parameter logic [7:0] TYPE_ID = 8'h5a,
  parameter logic [23:0] SERIAL_NO = 24'h00_0001,
  parameter logic [7:0] FW_VERSION = 8'h01
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_parity_err,
  input wire logic rx_sum_err,
  input wire logic [14:0] pos_raw,
  input wire logic [7:0] temp_c,
  input wire logic align_bad,
  input wire logic table_bad,
  input wire logic csum_bad,
  input wire logic wdog_restart,
  input wire logic overspeed,
  input wire logic st_unreliable,
  input wire logic current_crit,
  input wire logic temp_crit,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  output logic [7:0] status_code,
  output logic [7:0] enc_addr,
  output logic [7:0] mode_cfg,
  output logic busy
);
  import enc_cmd_pkg::*;

  // Type ID, serial and version defaults are arbitrary values

  state_t state, next_state;
  logic [7:0] rx_buf [BUF_BYTES];
  logic [7:0] next_rx_buf [BUF_BYTES];
  logic [7:0] rep [REP_BYTES];
  logic [7:0] next_rep [REP_BYTES];
  logic [3:0] cnt, next_cnt;
  logic [7:0] rx_fault, next_rx_fault;
  logic [2:0] rep_len, next_rep_len;
  logic [2:0] rep_idx, next_rep_idx;
  logic [7:0] next_status_code;
  logic [14:0] pos_ofs, next_pos_ofs;
  logic [15:0] counter, next_counter;
  logic [7:0] access_code, next_access_code;
  logic [7:0] next_enc_addr, next_mode_cfg;
  logic next_tx_valid, next_tx_last, next_busy;
  logic [7:0] next_tx_byte;
  logic [7:0] flt, flt_prev;
  logic [7:0] err;
  logic [14:0] pos_now;
  logic store_en, create_en;
  logic [15:0] fs_rdata;
  logic [7:0] fs_size, fs_free, fs_exist, fs_rd, fs_wr, fs_cr;

  // ==========================================================
  // Decoding helpers
  function automatic logic [3:0] req_len(input logic [7:0] c);
    case (c)
      CMD_POS_RD, CMD_CNT_RD, CMD_CNT_INC, CMD_FREE_RD: req_len = 4'd1;
      CMD_STATUS_RD, CMD_TYPE_RD, CMD_RESET, CMD_SERIAL_RD: req_len = 4'd1;
      CMD_ANALOG_RD, CMD_CNT_CLR, CMD_FIELD_STAT: req_len = 4'd2;
      CMD_DATA_RD, CMD_ACCESS_SET, CMD_ADDR_SET, CMD_IF_CFG: req_len = 4'd3;
      CMD_FIELD_NEW: req_len = 4'd4;
      CMD_POS_SET: req_len = 4'd4;
      CMD_DATA_WR: req_len = 4'd5;
      default: req_len = 4'd0;
    endcase
  endfunction

  // Access byte is always the last byte of these requests
  function automatic logic is_protected(input logic [7:0] c);
    is_protected = (c == CMD_POS_SET) || (c == CMD_CNT_CLR) || (c == CMD_FIELD_NEW) ||
                   (c == CMD_ADDR_SET) || (c == CMD_IF_CFG);
  endfunction

  // Most severe standing condition wins
  function automatic logic [7:0] lvl_code(input logic [7:0] f);
    if (f[FB_WDOG]) lvl_code = SC_WDOG;
    else if (f[FB_ALIGN]) lvl_code = SC_ALIGN;
    else if (f[FB_TABLE]) lvl_code = SC_TABLE;
    else if (f[FB_CSUM]) lvl_code = SC_CSUM_INT;
    else if (f[FB_SPEED]) lvl_code = SC_SPEED;
    else if (f[FB_ST_POS]) lvl_code = SC_ST_POS;
    else if (f[FB_CURRENT]) lvl_code = SC_CURRENT;
    else if (f[FB_TEMP]) lvl_code = SC_TEMP;
    else lvl_code = SC_OK;
  endfunction

  // ==========================================================
  // Fault pins come from the analog side, asynchronous to us
  pin_sync #(
    .WIDTH(FAULT_PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din({temp_crit, current_crit, st_unreliable, overspeed,
          wdog_restart, csum_bad, table_bad, align_bad}),
    .dout(flt)
  );

  field_store u_fields (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .store_en(store_en),
    .create_en(create_en),
    .field(rx_buf[1]),
    .word(rx_buf[2]),
    .new_size(rx_buf[2]),
    .wdata({rx_buf[3], rx_buf[4]}),
    .rdata(fs_rdata),
    .field_size(fs_size),
    .free_words(fs_free),
    .exist_fault(fs_exist),
    .rd_fault(fs_rd),
    .wr_fault(fs_wr),
    .cr_fault(fs_cr)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = state;
    next_rx_buf = rx_buf;
    next_rep = rep;
    next_cnt = cnt;
    next_rx_fault = rx_fault;
    next_rep_len = rep_len;
    next_rep_idx = rep_idx;
    next_status_code = status_code;
    next_pos_ofs = pos_ofs;
    next_counter = counter;
    next_access_code = access_code;
    next_enc_addr = enc_addr;
    next_mode_cfg = mode_cfg;
    next_tx_valid = 1'b0;
    next_tx_byte = tx_byte;
    next_tx_last = 1'b0;
    err = SC_OK;
    store_en = 1'b0;
    create_en = 1'b0;
    pos_now = pos_raw + pos_ofs;
    // A newly raised condition replaces the held code
    if (|(flt & ~flt_prev)) begin
      next_status_code = lvl_code(flt & ~flt_prev); // see RULE5 see RULE10 see RULE11 see RULE12
    end
    case (state)
      ST_IDLE: begin
        if (rx_valid && !busy) begin
          if (!cnt[3]) begin
            next_rx_buf[cnt[2:0]] = rx_byte;
          end
          if (cnt != 4'hf) begin
            next_cnt = cnt + 4'h1;
          end
          if (rx_parity_err) begin
            next_rx_fault = SC_PARITY; // see RULE6
          end else if (rx_last && rx_sum_err && rx_fault == SC_OK) begin
            next_rx_fault = SC_RX_SUM; // see RULE6
          end
          if (rx_last) begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_cnt = 4'h0;
        next_rx_fault = SC_OK;
        next_rep[0] = rx_buf[0];
        next_rep_len = 3'd1;
        next_rep_idx = 3'd0;
        if (rx_fault != SC_OK) begin
          err = rx_fault;
        end else if (req_len(rx_buf[0]) == 4'd0) begin
          err = SC_UNK_CMD; // see RULE6
        end else if (req_len(rx_buf[0]) != cnt) begin
          err = SC_LEN; // see RULE7
        end else if (is_protected(rx_buf[0]) && rx_buf[cnt[2:0] - 3'd1] != access_code) begin
          err = SC_ACCESS; // see RULE3 see RULE9
        end else begin
          case (rx_buf[0]) // see RULE1
            CMD_POS_RD: begin
              if (flt[FB_SPEED]) begin
                err = SC_SPEED; // see RULE10
              end else if (flt[FB_ST_POS]) begin
                err = SC_ST_POS; // see RULE10
              end else begin
                next_rep[1] = {1'b0, pos_now[14:8]};
                next_rep[2] = pos_now[7:0];
                next_rep_len = 3'd3;
              end
            end
            CMD_POS_SET: begin
              if (rx_buf[1][7]) begin
                err = SC_ARG; // see RULE7
              end else begin
                next_pos_ofs = {rx_buf[1][6:0], rx_buf[2]} - pos_raw;
              end
            end
            CMD_ANALOG_RD: begin
              if (rx_buf[1] != ANALOG_TEMP_CH) begin
                err = SC_ARG; // see RULE7
              end else begin
                next_rep[1] = temp_c;
                next_rep_len = 3'd2;
              end
            end
            CMD_CNT_RD: begin
              next_rep[1] = counter[15:8];
              next_rep[2] = counter[7:0];
              next_rep_len = 3'd3;
            end
            CMD_CNT_INC: begin
              if (counter == CNT_MAX) begin
                err = SC_CNT_OVF; // see RULE11
              end else begin
                next_counter = counter + 16'h0001;
              end
            end
            CMD_CNT_CLR: next_counter = CNT_RESET;
            CMD_DATA_RD: begin
              if (fs_rd != SC_OK) begin
                err = fs_rd; // see RULE2
              end else begin
                next_rep[1] = fs_rdata[15:8];
                next_rep[2] = fs_rdata[7:0];
                next_rep_len = 3'd3;
              end
            end
            CMD_DATA_WR: begin
              if (fs_wr != SC_OK) begin
                err = fs_wr;
              end else begin
                store_en = 1'b1; // see RULE2
              end
            end
            CMD_FIELD_STAT: begin
              if (fs_exist != SC_OK) begin
                err = fs_exist;
              end else begin
                next_rep[1] = fs_size; // see RULE2
                next_rep_len = 3'd2;
              end
            end
            CMD_FIELD_NEW: begin
              if (fs_cr != SC_OK) begin
                err = fs_cr;
              end else begin
                create_en = 1'b1; // see RULE2
              end
            end
            CMD_FREE_RD: begin
              // Words held internally, bytes reported
              next_rep[1] = {7'h00, fs_free[7]}; // see RULE2
              next_rep[2] = {fs_free[6:0], 1'b0};
              next_rep_len = 3'd3;
            end
            CMD_ACCESS_SET: begin
              if (rx_buf[1] != access_code) begin
                err = SC_ACCESS; // see RULE9
              end else begin
                next_access_code = rx_buf[2];
              end
            end
            CMD_STATUS_RD: begin
              next_rep[1] = status_code; // see RULE4 see RULE13
              next_rep_len = 3'd2;
              next_status_code = lvl_code(flt); // see RULE13
            end
            CMD_TYPE_RD: begin
              next_rep[1] = TYPE_ID;
              next_rep_len = 3'd2;
            end
            CMD_RESET: next_status_code = lvl_code(flt); // see RULE13
            CMD_ADDR_SET: next_enc_addr = rx_buf[1];
            CMD_SERIAL_RD: begin
              next_rep[1] = SERIAL_NO[23:16];
              next_rep[2] = SERIAL_NO[15:8];
              next_rep[3] = SERIAL_NO[7:0];
              next_rep[4] = FW_VERSION;
              next_rep_len = 3'd5;
            end
            CMD_IF_CFG: next_mode_cfg = rx_buf[1];
            default: err = SC_UNK_CMD;
          endcase
        end
        // Refused requests get no answer; the code waits for a status read
        if (err != SC_OK) begin
          next_status_code = err; // see RULE13 see RULE14
          next_state = ST_IDLE;
        end else begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        next_tx_valid = 1'b1;
        next_tx_byte = rep[rep_idx];
        next_tx_last = (rep_idx == rep_len - 3'd1);
        next_rep_idx = rep_idx + 3'd1;
        if (next_tx_last) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE) || next_tx_valid;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      for (int i = 0; i < BUF_BYTES; i++) begin
        rx_buf[i] <= 8'h00;
      end
      for (int i = 0; i < REP_BYTES; i++) begin
        rep[i] <= 8'h00;
      end
      cnt <= 4'h0;
      rx_fault <= SC_OK;
      rep_len <= 3'd0;
      rep_idx <= 3'd0;
      status_code <= SC_OK;
      pos_ofs <= OFS_RESET;
      counter <= CNT_RESET;
      access_code <= CODE0_RESET;
      enc_addr <= ADDR_RESET;
      mode_cfg <= MODE_RESET;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_last <= 1'b0;
      busy <= 1'b0;
      flt_prev <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      rx_buf <= next_rx_buf;
      rep <= next_rep;
      cnt <= next_cnt;
      rx_fault <= next_rx_fault;
      rep_len <= next_rep_len;
      rep_idx <= next_rep_idx;
      status_code <= next_status_code;
      pos_ofs <= next_pos_ofs;
      counter <= next_counter;
      access_code <= next_access_code;
      enc_addr <= next_enc_addr;
      mode_cfg <= next_mode_cfg;
      tx_valid <= next_tx_valid;
      tx_byte <= next_tx_byte;
      tx_last <= next_tx_last;
      busy <= next_busy;
      flt_prev <= flt;
    end
  end
endmodule // enc_cmd_status

// ===== enc_cmd_checker.sv
`timescale 1ns/1ns
module enc_cmd_checker
  import enc_cmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_parity_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic [7:0] status_code,
  input wire logic [7:0] enc_addr,
  input wire logic [7:0] mode_cfg,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic in_req;
  logic [7:0] cmd;
  wire take = rx_valid && !busy;
  // ==========================================================
  // Track command byte for the echo check
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_req <= 1'b0;
    end else if (take) begin
      in_req <= !rx_last;
    end
    if (take && !in_req) begin
      cmd <= rx_byte;
    end
  end
  // ==========================================================
  // Properties
  a_busy_after_last: assert property (take && rx_last |=> busy)
    else $error("no busy after last byte");
  a_echo_first: assert property ($rose(tx_valid) |-> tx_byte == cmd)
    else $error("echo mismatch");
  a_answer_time: assert property ($rose(tx_valid) |-> $past(take && rx_last, 3))
    else $error("answer at wrong cycle");
  a_tx_in_busy: assert property (tx_valid |-> busy)
    else $error("answer while not busy");
  a_reset_vals: assert property ($fell(rst) |-> status_code == SC_OK
    && enc_addr == 8'h40 && mode_cfg == 8'he4 && !busy && !tx_valid)
    else $error("bad reset values");
  a_parity_code: assert property (take && rx_last && rx_parity_err
    |=> ##2 status_code == SC_PARITY && !tx_valid)
    else $error("parity not reported");
  a_last_ends: assert property (tx_last |-> tx_valid ##1 (!busy && !tx_valid))
    else $error("answer did not end");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:10] !busy)
    else $error("request hung");
  a_cfg_stable: assert property (!busy && !rx_valid
    |=> $stable(enc_addr) && $stable(mode_cfg))
    else $error("config changed while idle");
  c_answer: cover property (tx_last);
  c_parity: cover property (take && rx_last && rx_parity_err);
  c_busy: cover property ($rose(busy));
endmodule // enc_cmd_checker

bind enc_cmd_status enc_cmd_checker u_chk (.*);

// ===== drive_ctrl_model.sv
`timescale 1ns/1ns
module drive_ctrl_model (
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_last,
  output logic rx_parity_err,
  output logic rx_sum_err
);
  logic [7:0] ans[$];
  logic [7:0] last_status;
  initial {rx_valid, rx_byte, rx_last, rx_parity_err, rx_sum_err} = '0;
  always @(posedge ref_clk) begin
    if (tx_valid) begin
      ans.push_back(tx_byte);
    end
  end
  // ==========================================================
  // Request bytes back to back, command first
  task automatic put(input int n, input logic [39:0] req, input logic pe, input logic se);
    int k;
    ans.delete();
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte <= req[8*(n-1-i) +: 8];
      rx_last <= (i == n - 1);
      rx_parity_err <= pe && (i == n - 1);
      rx_sum_err <= se && (i == n - 1);
    end
    @(posedge ref_clk);
    {rx_valid, rx_last, rx_parity_err, rx_sum_err} <= '0;
    // Flip idle byte so stale data shows
    rx_byte <= ~rx_byte;
    for (k = 0; k < 40; k++) begin
      @(negedge ref_clk);
      if (k > 2 && !busy) break;
    end
  endtask
  // Silence means refusal: fetch the code
  task automatic send(input int n, input logic [39:0] req, input logic pe, input logic se);
    put(n, req, pe, se);
    if (ans.size() == 0) begin
      put(1, 40'h50, 1'b0, 1'b0);
      last_status = (ans.size() > 1) ? ans[1] : 8'hxx;
      ans.delete();
    end
  endtask
endmodule // drive_ctrl_model

// ===== tb_encoder_param_cmd_status.sv
`timescale 1ns/1ns
module tb_encoder_param_cmd_status;
  import enc_cmd_pkg::*;
  // Arbitrary identity values
  localparam logic [7:0] TB_TYPE = 8'h3c;
  localparam logic [23:0] TB_SER = 24'h12_3456;
  localparam logic [7:0] TB_FW = 8'h07;
  localparam logic [7:0] ACC = 8'h55;
  logic ref_clk, rst, clk_en, rx_valid, rx_last, rx_parity_err, rx_sum_err;
  logic tx_valid, tx_last, busy;
  logic [7:0] rx_byte, temp_c, tx_byte, status_code, enc_addr, mode_cfg, pins;
  logic [14:0] pos_raw;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  enc_cmd_status #(.TYPE_ID(TB_TYPE), .SERIAL_NO(TB_SER), .FW_VERSION(TB_FW)) dut (.*,
    .align_bad(pins[FB_ALIGN]), .table_bad(pins[FB_TABLE]), .csum_bad(pins[FB_CSUM]),
    .wdog_restart(pins[FB_WDOG]), .overspeed(pins[FB_SPEED]), .st_unreliable(pins[FB_ST_POS]),
    .current_crit(pins[FB_CURRENT]), .temp_crit(pins[FB_TEMP]));
  drive_ctrl_model drv (.*);
  // ==========================================================
  // Expectations and comparisons
  function automatic logic [7:0] pin_code(input int i);
    case (i)
      FB_ALIGN: return SC_ALIGN;
      FB_TABLE: return SC_TABLE;
      FB_CSUM: return SC_CSUM_INT;
      FB_WDOG: return SC_WDOG;
      FB_SPEED: return SC_SPEED;
      FB_ST_POS: return SC_ST_POS;
      FB_CURRENT: return SC_CURRENT;
      default: return SC_TEMP;
    endcase
  endfunction
  function automatic logic [15:0] free_bytes(input int used);
    return 16'(2 * (FREE_RESET - used));
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_ans(input string name, input int n, input logic [39:0] exp);
    chk8({name, " length"}, 8'(n), 8'(drv.ans.size()));
    for (int i = 0; i < n && i < drv.ans.size(); i++) begin
      chk8(name, exp[8*(n-1-i) +: 8], drv.ans[i]);
    end
  endtask
  task automatic send_req(input int n, input logic [39:0] r);
    drv.send(n, r, 1'b0, 1'b0);
  endtask
  task automatic err(input int n, input logic [39:0] r, input logic pe, input logic se,
                     input logic [7:0] code);
    drv.send(n, r, pe, se);
    chk_ans("refused", 0, 40'h0);
    chk8("held code", code, drv.last_status);
    chk8("reloaded", SC_OK, status_code);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] d;
    logic [14:0] tgt;
    logic [7:0] a;
    int k;
    rst = 1'b1;
    clk_en = 1'b1;
    pins = 8'h00;
    temp_c = 8'h00;
    pos_raw = 15'h0000;
    void'($urandom(54));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    pos_raw <= 15'($urandom);
    temp_c <= 8'($urandom);
    @(negedge ref_clk);
    chk8("status", SC_OK, status_code);
    chk8("addr", ADDR_RESET, enc_addr);
    send_req(1, CMD_STATUS_RD);
    chk_ans("status rd", 2, {CMD_STATUS_RD, SC_OK});
    send_req(1, CMD_TYPE_RD);
    chk_ans("type", 2, {CMD_TYPE_RD, TB_TYPE});
    send_req(1, CMD_SERIAL_RD);
    chk_ans("serial", 5, {CMD_SERIAL_RD, TB_SER, TB_FW});
    send_req(2, {CMD_ANALOG_RD, ANALOG_TEMP_CH});
    chk_ans("temp", 2, {CMD_ANALOG_RD, temp_c});
    k = $urandom_range(4, 1);
    repeat (k) send_req(1, CMD_CNT_INC);
    send_req(1, CMD_CNT_RD);
    chk_ans("count", 3, {CMD_CNT_RD, 16'(k)});
    send_req(2, {CMD_CNT_CLR, ACC});
    send_req(1, CMD_CNT_RD);
    chk_ans("cleared", 3, {CMD_CNT_RD, CNT_RESET});
    tgt = 15'($urandom);
    send_req(4, {CMD_POS_SET, 1'b0, tgt, ACC});
    send_req(1, CMD_POS_RD);
    chk_ans("position", 3, {CMD_POS_RD, 1'b0, tgt});
    a = 8'($urandom_range(127, 1));
    send_req(3, {CMD_ADDR_SET, a, ACC});
    chk8("new addr", a, enc_addr);
    send_req(3, {CMD_IF_CFG, MODE_RESET ^ 8'h01, ACC});
    chk8("new mode", MODE_RESET ^ 8'h01, mode_cfg);
    d = 16'($urandom);
    send_req(4, {CMD_FIELD_NEW, 8'h01, 8'h02, ACC});
    send_req(5, {CMD_DATA_WR, 8'h01, 8'h01, d});
    send_req(3, {CMD_DATA_RD, 8'h01, 8'h01});
    chk_ans("data", 3, {CMD_DATA_RD, d});
    send_req(2, {CMD_FIELD_STAT, 8'h01});
    chk_ans("size", 2, {CMD_FIELD_STAT, 8'h02});
    send_req(1, CMD_FREE_RD);
    chk_ans("free", 3, {CMD_FREE_RD, free_bytes(2)});
    err(1, CMD_STATUS_RD, 1'b1, 1'b0, SC_PARITY);
    err(1, CMD_STATUS_RD, 1'b0, 1'b1, SC_RX_SUM);
    err(1, 8'h41, 1'b0, 1'b0, SC_UNK_CMD);
    err(2, {CMD_STATUS_RD, 8'h00}, 1'b0, 1'b0, SC_LEN);
    err(4, {CMD_FIELD_NEW, 8'h02, 8'h00, ACC}, 1'b0, 1'b0, SC_ARG);
    err(2, {CMD_CNT_CLR, ~ACC}, 1'b0, 1'b0, SC_ACCESS);
    err(4, {CMD_FIELD_NEW, 8'h01, 8'h02, ACC}, 1'b0, 1'b0, SC_FIXED);
    err(5, {CMD_DATA_WR, 8'h00, 8'h00, d}, 1'b0, 1'b0, SC_WR_PROT);
    err(3, {CMD_DATA_RD, 8'h01, 8'h02}, 1'b0, 1'b0, SC_WORD);
    err(3, {CMD_DATA_RD, 8'h09, 8'h00}, 1'b0, 1'b0, SC_NO_FIELD);
    for (int i = 0; i < FAULT_PINS; i++) begin
      @(posedge ref_clk);
      pins[i] <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk8("pin code", pin_code(i), status_code);
      @(posedge ref_clk);
      pins[i] <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk8("pin held", pin_code(i), status_code);
      send_req(1, CMD_STATUS_RD);
      chk8("pin cleared", SC_OK, status_code);
    end
    give_verdict();
  end
endmodule // tb_encoder_param_cmd_status
